// File: srs_map.svh
// Timing constants and widths for the sensor reset and standby sequencer.
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH
`define SRS_CLK_PERIOD_NS 25
`define SRS_RESET_MIN_NS 750
`define SRS_RESET_MIN_CYC ((`SRS_RESET_MIN_NS + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_SERIAL_WAIT_EDGES 10
`define SRS_DEAD_MARGIN_ROWS 5
`define SRS_ROW_LEN_CYC 16
`define SRS_ACTIVE_ROWS 8
`define SRS_CNT_W 16
`define SRS_VB_W 9
`define SRS_VB_DEFAULT 9'h02d
`define SRS_DATA_W 10
`endif

// File: srs_pkg.sv
// State types of the two ends of the reset and standby sequencer, one enum per end.
package srs_pkg;
  typedef enum logic [2:0] {
    SRS_RESET,
    SRS_ACTIVE,
    SRS_BLANK,
    SRS_STANDBY,
    SRS_LOCKED
  } srs_state_e;
  typedef enum logic [2:0] {
    SRH_POWERUP,
    SRH_HOLD,
    SRH_SETTLE,
    SRH_RUN,
    SRH_SLEEP
  } srh_state_e;
endpackage

// File: srs_if.sv
// Pin-level carrier between the host and the sensor sequencer.
`timescale 1ns/100ps
`include "srs_map.svh"
interface srs_if;
  logic reset_n;
  logic master_clock_in;
  logic standby;
  logic frame_valid;
  logic line_valid;
  logic [`SRS_DATA_W-1:0] dout;
  logic out_oe;
  logic serial_ready;
  modport sensor (
    input reset_n, master_clock_in, standby,
    output frame_valid, line_valid, dout, out_oe, serial_ready
  );
  modport host (
    output reset_n, master_clock_in, standby,
    input frame_valid, line_valid, dout, out_oe, serial_ready
  );
endinterface

// File: srs_sensor.sv
// Sensor end: reset, frame timing, standby entry and dead-zone lock.
`timescale 1ns/100ps
`include "srs_map.svh"
module srs_sensor (
  // System clock and pins.
  input wire logic clk_sys_i,
  srs_if.sensor pins,
  // Configuration.
  input wire logic [`SRS_VB_W-1:0] vblank_rows_i,
  // Status.
  output logic standby_o,
  output logic locked_o
);
  typedef struct packed {
    srs_pkg::srs_state_e st;
    logic [2:0] stby_sync;
    logic stby;
    logic stby_d;
    logic [`SRS_CNT_W-1:0] col;
    logic [`SRS_CNT_W-1:0] row;
    logic [3:0] ser_cnt;
    logic [`SRS_VB_W-1:0] vb;
    logic fv;
    logic lv;
    logic [`SRS_DATA_W-1:0] dat;
  } srs_state_s;

  srs_state_s state_r;
  srs_state_s state_nxt;
  logic rst_pin;

  // Row index at which the dead zone opens and closes inside blanking.
  function automatic logic [`SRS_CNT_W-1:0] blank_row(input logic [`SRS_VB_W-1:0] vb,
                                                      input logic plus);
    logic [`SRS_CNT_W-1:0] base;
    base = `SRS_CNT_W'(vb);
    if (plus) begin
      blank_row = base + `SRS_CNT_W'(`SRS_DEAD_MARGIN_ROWS);
    end else begin
      blank_row = (base > `SRS_CNT_W'(`SRS_DEAD_MARGIN_ROWS)) ?
                  base - `SRS_CNT_W'(`SRS_DEAD_MARGIN_ROWS) : '0;
    end
  endfunction

  // True on the last column of a row, where the row counter advances.
  function automatic logic last_col(input logic [`SRS_CNT_W-1:0] col);
    last_col = (col == `SRS_CNT_W'(`SRS_ROW_LEN_CYC - 1));
  endfunction

  // True while a blanking row lies inside the window where a standby change
  // can wedge the frame timer. Holding standby steady through it is harmless;
  // only a change of level there is dangerous, so callers pair it with an edge.
  function automatic logic in_dead_zone(input logic [`SRS_CNT_W-1:0] row,
                                        input logic [`SRS_VB_W-1:0] vb);
    in_dead_zone = (row >= blank_row(vb, 1'b0)) && (row < blank_row(vb, 1'b1));
  endfunction

  // The reset pin acts as a synchronous reset; pin level is sampled each edge.
  assign rst_pin = ~pins.reset_n;

  // Next-state logic for frame timing and standby.
  always_comb begin
    state_nxt = state_r;
    state_nxt.stby_sync = {state_r.stby_sync[1:0], pins.standby};
    if (state_r.stby_sync[2] == state_r.stby_sync[1]) begin
      state_nxt.stby = state_r.stby_sync[2];
    end
    // Delayed copy of the filtered request, so a change of level can be seen.
    state_nxt.stby_d = state_r.stby;
    state_nxt.lv = 1'b0;
    state_nxt.dat = '0;
    if (last_col(state_r.col)) begin
      state_nxt.col = '0;
      state_nxt.row = state_r.row + `SRS_CNT_W'(1);
    end else begin
      state_nxt.col = state_r.col + `SRS_CNT_W'(1);
    end
    if (state_r.ser_cnt != 4'h0) begin
      state_nxt.ser_cnt = state_r.ser_cnt - 4'h1;
    end
    unique case (state_r.st)
      srs_pkg::SRS_RESET: begin
        state_nxt.st = srs_pkg::SRS_ACTIVE;
        state_nxt.col = '0;
        state_nxt.row = '0;
        state_nxt.fv = 1'b1;
      end
      srs_pkg::SRS_ACTIVE: begin
        state_nxt.fv = 1'b1;
        state_nxt.lv = 1'b1;
        state_nxt.dat = state_r.col[`SRS_DATA_W-1:0] ^ state_r.row[`SRS_DATA_W-1:0];
        if (last_col(state_r.col) &&
            state_r.row == `SRS_CNT_W'(`SRS_ACTIVE_ROWS - 1)) begin
          state_nxt.st = srs_pkg::SRS_BLANK;
          state_nxt.row = '0;
          state_nxt.fv = 1'b0;
          state_nxt.lv = 1'b0;
          state_nxt.vb = vblank_rows_i;
          if (state_r.stby) begin
            state_nxt.st = srs_pkg::SRS_STANDBY;
          end
        end
      end
      srs_pkg::SRS_BLANK: begin
        state_nxt.fv = 1'b0;
        // A standby level change inside the dead zone wedges the sequencer.
        if ((state_r.stby != state_r.stby_d) &&
            in_dead_zone(state_r.row, state_r.vb)) begin
          state_nxt.st = srs_pkg::SRS_LOCKED;
        end else if (last_col(state_r.col) &&
                     state_r.row >= `SRS_CNT_W'(state_r.vb)) begin
          state_nxt.row = '0;
          if (state_r.stby) begin
            state_nxt.st = srs_pkg::SRS_STANDBY;
          end else begin
            state_nxt.st = srs_pkg::SRS_ACTIVE;
            state_nxt.fv = 1'b1;
          end
        end
      end
      srs_pkg::SRS_STANDBY: begin
        state_nxt.fv = 1'b0;
        state_nxt.col = '0;
        state_nxt.row = '0;
        if (!state_r.stby) begin
          state_nxt.st = srs_pkg::SRS_ACTIVE;
          state_nxt.fv = 1'b1;
        end
      end
      srs_pkg::SRS_LOCKED: begin
        state_nxt.fv = 1'b0;
        state_nxt.col = '0;
        state_nxt.row = '0;
      end
    endcase
  end

  // State register; pin reset restores every default, including lock.
  always_ff @(posedge clk_sys_i) begin
    if (rst_pin) begin
      state_r.st <= srs_pkg::SRS_RESET;
      state_r.stby_sync <= 3'h0;
      state_r.stby <= 1'b0;
      state_r.stby_d <= 1'b0;
      state_r.col <= '0;
      state_r.row <= '0;
      state_r.ser_cnt <= 4'(`SRS_SERIAL_WAIT_EDGES);
      state_r.vb <= `SRS_VB_DEFAULT;
      state_r.fv <= 1'b0;
      state_r.lv <= 1'b0;
      state_r.dat <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pin outputs are forced to fixed levels by the pin reset alone, clock or not;
  // the core keeps running its clocks in reset, so no low-power mode exists.
  always_comb begin
    pins.frame_valid = rst_pin ? 1'b0 : state_r.fv;
    pins.line_valid = rst_pin ? 1'b0 : state_r.lv;
    pins.dout = rst_pin ? '0 : state_r.dat;
    pins.out_oe = ~(state_r.st == srs_pkg::SRS_STANDBY ||
                    state_r.st == srs_pkg::SRS_LOCKED) | rst_pin;
    pins.serial_ready = ~rst_pin && state_r.ser_cnt == 4'h0 &&
                        state_r.st != srs_pkg::SRS_STANDBY &&
                        state_r.st != srs_pkg::SRS_LOCKED;
  end

  assign standby_o = state_r.st == srs_pkg::SRS_STANDBY || state_r.st == srs_pkg::SRS_LOCKED;
  assign locked_o = state_r.st == srs_pkg::SRS_LOCKED;
endmodule

// File: srs_host.sv
// Host end: drives reset, the sensor clock and a safely timed standby pin.
`timescale 1ns/100ps
`include "srs_map.svh"
module srs_host (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Pins toward the sensor.
  srs_if.host pins,
  // User side.
  input wire logic sleep_req_i,
  input wire logic [`SRS_VB_W-1:0] vblank_rows_i,
  output logic serial_ok_o,
  output logic asleep_o
);
  typedef struct packed {
    srs_pkg::srh_state_e st;
    logic [`SRS_CNT_W-1:0] cnt;
    logic rst_n;
    logic stby;
    logic fv_d;
  } srh_state_s;

  srh_state_s state_r;
  srh_state_s state_nxt;

  // Hold time in cycles for a request raised at a frame-valid fall.
  function automatic logic [`SRS_CNT_W-1:0] hold_cyc(input logic [`SRS_VB_W-1:0] vb);
    hold_cyc = `SRS_CNT_W'((`SRS_CNT_W'(vb) + `SRS_CNT_W'(`SRS_DEAD_MARGIN_ROWS) +
               `SRS_CNT_W'(`SRS_ACTIVE_ROWS)) * `SRS_CNT_W'(`SRS_ROW_LEN_CYC));
  endfunction

  // Sequencing of reset, settle wait and standby requests.
  always_comb begin
    state_nxt = state_r;
    state_nxt.fv_d = pins.frame_valid;
    if (state_r.cnt != '0) begin
      state_nxt.cnt = state_r.cnt - `SRS_CNT_W'(1);
    end
    unique case (state_r.st)
      srs_pkg::SRH_POWERUP: begin
        state_nxt.st = srs_pkg::SRH_HOLD;
        state_nxt.cnt = `SRS_CNT_W'(`SRS_RESET_MIN_CYC);
      end
      srs_pkg::SRH_HOLD: begin
        if (state_r.cnt == '0) begin
          state_nxt.rst_n = 1'b1;
          state_nxt.st = srs_pkg::SRH_SETTLE;
          state_nxt.cnt = `SRS_CNT_W'(`SRS_SERIAL_WAIT_EDGES);
        end
      end
      srs_pkg::SRH_SETTLE: begin
        if (state_r.cnt == '0) begin
          state_nxt.st = srs_pkg::SRH_RUN;
        end
      end
      srs_pkg::SRH_RUN: begin
        // Raise only at a frame-valid fall, outside the blanking dead zone.
        if (sleep_req_i && state_r.fv_d && !pins.frame_valid) begin
          state_nxt.stby = 1'b1;
          state_nxt.st = srs_pkg::SRH_SLEEP;
          state_nxt.cnt = hold_cyc(vblank_rows_i);
        end
      end
      srs_pkg::SRH_SLEEP: begin
        if (state_r.cnt == '0 && !sleep_req_i) begin
          state_nxt.stby = 1'b0;
          state_nxt.st = srs_pkg::SRH_RUN;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r.st <= srs_pkg::SRH_POWERUP;
      state_r.cnt <= '0;
      state_r.rst_n <= 1'b0;
      state_r.stby <= 1'b0;
      state_r.fv_d <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The sensor clock is the host clock, kept running in every state.
  assign pins.master_clock_in = clk_sys_i;
  assign pins.reset_n = state_r.rst_n;
  assign pins.standby = state_r.stby;
  assign serial_ok_o = state_r.st == srs_pkg::SRH_RUN && pins.serial_ready;
  assign asleep_o = state_r.st == srs_pkg::SRH_SLEEP;
endmodule

// File: srs_properties.sv
// Checker of the pin-level relations between the host and sensor ends.
`timescale 1ns/100ps
`include "srs_map.svh"
module srs_properties (
  // Clock, reset and configuration.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [`SRS_VB_W-1:0] vblank_rows_i,
  // Carrier pins.
  input wire logic reset_n,
  input wire logic standby,
  input wire logic frame_valid,
  input wire logic line_valid,
  input wire logic [`SRS_DATA_W-1:0] dout,
  input wire logic out_oe,
  input wire logic serial_ready
);
  localparam int RST_CYC = `SRS_RESET_MIN_CYC;
  localparam int ROW = `SRS_ROW_LEN_CYC;
  logic [15:0] low_r;
  logic [15:0] high_r;
  logic [15:0] sb_r;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Cycles of sensor reset low, of reset high and of standby high.
  always_ff @(posedge clk_sys_i) begin
    low_r <= (reset_i || reset_n) ? 16'h0000 : low_r + 16'h0001;
    high_r <= !reset_n ? 16'h0000 : high_r + 16'h0001;
    sb_r <= standby ? sb_r + 16'h0001 : 16'h0000;
  end
  property p_rst_out; !reset_n |-> !frame_valid && !line_valid && dout == 10'h000 && out_oe;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle in reset");
  property p_rst_len; $rose(reset_n) |-> low_r >= RST_CYC; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
  property p_ser; serial_ready |-> high_r >= `SRS_SERIAL_WAIT_EDGES; endproperty
  a_ser: assert property (p_ser) else $error("serial ready too early");
  property p_frame; out_oe && frame_valid |=> out_oe; endproperty
  a_frame: assert property (p_frame) else $error("frame cut short");
  property p_float; !out_oe |-> !frame_valid && !line_valid; endproperty
  a_float: assert property (p_float) else $error("sync active while floated");
  property p_ser_sb; !out_oe |-> !serial_ready; endproperty
  a_ser_sb: assert property (p_ser_sb) else $error("serial ready in standby");
  property p_req; $rose(standby) |-> !frame_valid && ($past(frame_valid, 2) ||
    $past(frame_valid, 3)); endproperty
  a_req: assert property (p_req) else $error("standby raised off frame end");
  property p_hold; $fell(standby) |-> int'(sb_r) >= (int'(vblank_rows_i) + 5) * ROW;
  endproperty
  a_hold: assert property (p_hold) else $error("standby held too briefly");
  property p_sync; $rose(standby) |-> out_oe [*3]; endproperty
  a_sync: assert property (p_sync) else $error("standby acted on unsynced");
  // Main scenarios.
  c_sleep: cover property ($fell(out_oe));
  c_wake: cover property ($fell(standby));
  c_serial: cover property ($rose(serial_ready));
endmodule

// File: tb_sensor_reset_standby_sequencer.sv
// Self-checking bench for the host and sensor ends of the sequencer.
`timescale 1ns/100ps
`include "srs_map.svh"
module tb_sensor_reset_standby_sequencer;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic sleep_req = 1'b0;
  logic [`SRS_VB_W-1:0] vb = 9'h006;
  logic rst1_n = 1'b0;
  logic sb1 = 1'b0;
  logic fv_prev = 1'b0;
  logic serial_ok, asleep, standby0, locked0, standby1, locked1;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int t_fall = 0;
  int k;
  srs_if if0 ();
  srs_if if1 ();
  // The second carrier is driven by the bench to break standby timing on purpose.
  assign if1.reset_n = rst1_n;
  assign if1.master_clock_in = clk_sys_i;
  assign if1.standby = sb1;
  always #12.5 clk_sys_i = ~clk_sys_i;
  srs_host srs_host_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pins(if0.host),
    .sleep_req_i(sleep_req), .vblank_rows_i(vb), .serial_ok_o(serial_ok), .asleep_o(asleep));
  srs_sensor srs_sensor_inst (.clk_sys_i(clk_sys_i), .pins(if0.sensor), .vblank_rows_i(vb),
    .standby_o(standby0), .locked_o(locked0));
  srs_sensor srs_sensor_inst2 (.clk_sys_i(clk_sys_i), .pins(if1.sensor),
    .vblank_rows_i(9'h008), .standby_o(standby1), .locked_o(locked1));
  srs_properties srs_properties_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .vblank_rows_i(vb), .reset_n(if0.reset_n), .standby(if0.standby),
    .frame_valid(if0.frame_valid), .line_valid(if0.line_valid), .dout(if0.dout),
    .out_oe(if0.out_oe), .serial_ready(if0.serial_ready));
  // Shortest gap from frame end to standby: the blanking rows still to read out.
  function automatic int min_gap(int v);
    return v * `SRS_ROW_LEN_CYC;
  endfunction
  // Delay after frame end that lands the request inside the dead zone.
  function automatic int dz_at(int v);
    return (v - 3) * `SRS_ROW_LEN_CYC;
  endfunction
  task automatic tick();
    @(posedge clk_sys_i);
    #2;
  endtask
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Cycle count, frame-end time stamp and hang limit.
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    fv_prev <= if0.frame_valid;
    if (fv_prev && !if0.frame_valid) begin
      t_fall <= cyc;
    end
    if (cyc == 60000) begin
      failures++;
      stop_test();
    end
  end
  // Main sequence.
  initial begin
    void'($urandom(35372));
    repeat (20) tick();
    check({if1.frame_valid, if1.line_valid, if1.out_oe}, 3'b001);
    reset_i = 1'b0;
    repeat (20) tick();
    rst1_n = 1'b1;
    for (k = 0; k < 300 && serial_ok !== 1'b1; k++) tick();
    check({serial_ok, if0.serial_ready, asleep}, 3'b110);
    // Requests at random moments, the first at the smallest safe blanking.
    for (int i = 0; i < 4; i++) begin
      vb = (i == 0) ? 9'h006 : 9'(6 + $urandom % 35);
      repeat ($urandom % 300) tick();
      sleep_req = 1'b1;
      for (k = 0; k < 4000 && standby0 !== 1'b1; k++) tick();
      check(16'(cyc - t_fall >= min_gap(int'(vb))), 16'h0001);
      check({asleep, if0.out_oe, if0.serial_ready, locked0}, 4'h8);
      check({if0.line_valid, if0.dout}, 16'h0000);
      repeat ($urandom % 100) tick();
      sleep_req = 1'b0;
      for (k = 0; k < 6000 && if0.frame_valid !== 1'b1; k++) tick();
      check({standby0, locked0, if0.out_oe, asleep}, 4'h2);
    end
    // Request inside the dead zone of the second sensor.
    for (k = 0; k < 2000 && if1.frame_valid !== 1'b1; k++) tick();
    for (k = 0; k < 2000 && if1.frame_valid !== 1'b0; k++) tick();
    repeat (dz_at(8)) tick();
    sb1 = 1'b1;
    repeat (12 * `SRS_ROW_LEN_CYC) tick();
    sb1 = 1'b0;
    check({locked1, standby1}, 2'b11);
    for (k = 0; k < 1000 && if1.frame_valid !== 1'b1; k++) tick();
    check(if1.frame_valid, 1'b0);
    rst1_n = 1'b0;
    repeat (40) tick();
    check({locked1, if1.frame_valid, if1.out_oe}, 3'b001);
    rst1_n = 1'b1;
    for (k = 0; k < 1000 && if1.frame_valid !== 1'b1; k++) tick();
    check({locked1, standby1, if1.frame_valid}, 3'b001);
    stop_test();
  end
endmodule
